// ==== design/vpw_bus_mux_interface.sv ====
// vpw bus mux interface: rx filter, symbol decode, crc, transmitter
// assumes raw lines synchronous to clk, line high means active
//
// Summary of operation
// R1: sample raw line, update counter afterwards
// R2: counter counts up on high, down on low
// R3: at 15 output goes high, counter saturates
// R4: at 0 output goes low, counter saturates
// R5: output holds between the end points
// R6: clean edge appears after 15 to 16 clocks
// R7: at most 12 bytes, msb first
// R8: frames open with 200 us active sof
// R9: at least one data byte plus crc
// R10: crc x8+x4+x3+x2+1, preset ones, inverted
// R11: received remainder not c4 flags crc error
// R12: 200 us passive ends data, no flag
// R13: 280 us passive sets end-of-frame flag
// R14: wait further 20 us before next sof
// R15: resync to rising edge during separation
// R16: write within 104 clocks of edge transmits
// R17: later write waits for next separation
// R18: receiver accepts sof during separation
// R19: never send break; break aborts transmit
// R20: break in receive flags invalid, discards
// R21: break in receive clears 4x enable
// R22: passive past 300 us is idle bus
// R23: logic 0 is short passive or long active
// R24: logic 1 is long passive or short active
`timescale 1ns/1ps
module vpw_bus_mux_interface
(
  input wire logic clk,
  input wire logic rst,
  input vpw_mux_pkg::wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic raw_receive_line,
  output logic raw_transmit_line
);
  import vpw_mux_pkg::*;

  // one crc step for one message bit
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction

  // ***************************************
  // receive filter
  // ***************************************
  logic sample; // raw line taken at the clock edge
  logic [3:0] filt_cnt; // saturating up/down counter
  logic [3:0] next_filt_cnt;
  logic rx_filt; // filtered line
  logic rx_prev; // filtered line one clock back

  // step toward the sample, stop at the end points
  assign next_filt_cnt = (sample && filt_cnt != FILT_MAX) ? 4'(filt_cnt + 4'h1) : // R2 R3
    (!sample && filt_cnt != FILT_MIN) ? 4'(filt_cnt - 4'h1) : filt_cnt; // R2 R4

  // sample, then update the counter from the held sample one clock later
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sample <= 1'b0;
      filt_cnt <= FILT_MIN;
      rx_filt <= 1'b0;
      rx_prev <= 1'b0;
    end
    else
    begin
      sample <= raw_receive_line; // R1
      filt_cnt <= next_filt_cnt; // R1
      if (next_filt_cnt == FILT_MAX)
        rx_filt <= 1'b1; // R3 R6
      else if (next_filt_cnt == FILT_MIN)
        rx_filt <= 1'b0; // R4
      rx_prev <= rx_filt; // R5
    end
  end

  // ***************************************
  // symbol timing and decode
  // ***************************************
  logic fourx; // fourx_receive_enable
  logic [11:0] rx_time; // clocks since the last filtered edge, four counts per clock in 4x mode
  logic brk_done; // break already reported in this active period
  rx_state_t rx_state;
  logic [7:0] rx_crc;
  logic [7:0] rx_shift;
  logic [2:0] rx_bits;
  logic [7:0] rx_data; // last complete byte

  wire rise = rx_filt & ~rx_prev;
  wire fall = ~rx_filt & rx_prev;
  wire edge_seen = rise | fall;
  // 4x mode runs the receive timebase four times faster
  wire [11:0] rx_step = fourx ? 12'h004 : 12'h001;
  wire in_frame = (rx_state == RX_SOF) || (rx_state == RX_DATA);
  wire len_ok = (rx_time >= C_MIN) && (rx_time < C_LMAX);
  // passive ends: long means 1; active ends: short means 1
  wire bit_val = rise ? (rx_time >= C_SPLIT) : (rx_time < C_SPLIT); // R23 R24
  wire rx_bit_ev = (rx_state == RX_DATA) && edge_seen && len_ok;
  wire rx_bad_bit = (rx_state == RX_DATA) && edge_seen && !len_ok;
  wire sof_ok = (rx_state == RX_SOF) && fall && (rx_time >= C_LMAX);
  wire sof_bad = (rx_state == RX_SOF) && fall && (rx_time < C_LMAX);
  // on a rise rx_time still holds the passive length, so only a continued active counts
  wire brk_hit = rx_filt && rx_prev && (rx_time >= C_BREAK) && !brk_done;
  wire rx_brk = brk_hit && in_frame;
  wire eod_ev = (rx_state == RX_DATA) && !rx_filt && (rx_time >= C_EOD); // R12
  wire eof_ev = (rx_state == RX_EOD) && (rx_time >= C_EOF); // R13
  wire idle_ev = (rx_state == RX_IFS) && (rx_time >= C_IDLE); // R14
  wire bus_idle = (rx_state == RX_IDLE) && !rx_filt && (rx_time >= C_IDLE); // R22
  wire [7:0] rx_crc_nx = crc_step(rx_crc, bit_val);

  // timebase since the last edge, saturating
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_time <= 12'h000;
      brk_done <= 1'b0;
    end
    else if (edge_seen)
    begin
      rx_time <= 12'h000;
      brk_done <= 1'b0;
    end
    else
    begin
      if (rx_time < C_TIME_SAT)
        rx_time <= 12'(rx_time + rx_step);
      if (brk_hit)
        brk_done <= 1'b1;
    end
  end

  // frame tracking
  always_ff @(posedge clk)
  begin
    if (rst)
      rx_state <= RX_IDLE;
    else if (rx_brk || rx_bad_bit || sof_bad)
      rx_state <= RX_IDLE; // R20
    else
    begin
      case (rx_state)
        RX_IDLE: if (rise) rx_state <= RX_SOF;
        RX_SOF: if (sof_ok) rx_state <= RX_DATA;
        RX_DATA: if (eod_ev) rx_state <= RX_EOD; // R12
        RX_EOD:
        begin
          // a response is not decoded; a new edge restarts
          if (rise)
            rx_state <= RX_SOF;
          else if (eof_ev)
            rx_state <= RX_IFS; // R13
        end
        RX_IFS:
        begin
          if (rise)
            rx_state <= RX_SOF; // R18
          else if (idle_ev)
            rx_state <= RX_IDLE; // R22
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // byte assembly and crc check, msb first
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_crc <= CRC_INIT;
      rx_shift <= 8'h00;
      rx_bits <= 3'h0;
      rx_data <= 8'h00;
    end
    else if (sof_ok)
    begin
      rx_crc <= CRC_INIT;
      rx_bits <= 3'h0;
    end
    else if (rx_bit_ev)
    begin
      rx_crc <= rx_crc_nx; // R11
      rx_shift <= {rx_shift[6:0], bit_val}; // R7
      rx_bits <= 3'(rx_bits + 3'h1);
      if (rx_bits == 3'h7)
        rx_data <= {rx_shift[6:0], bit_val};
    end
  end

  // ***************************************
  // transmitter
  // ***************************************
  tx_state_t tx_state;
  logic [11:0] tx_time; // clocks into the current symbol
  logic [7:0] tx_shift;
  logic [2:0] tx_bits;
  logic [7:0] tx_crc;
  logic tx_crc_phase; // crc byte is on the line
  logic [3:0] tx_nbytes;
  logic [7:0] hold; // byte written by software
  logic pending;
  logic [6:0] sync_age; // clocks since a rise in the separation
  logic sync_ok;
  status_t flags;

  wire [11:0] sym_len = (raw_transmit_line ^ tx_shift[7]) ? C_LONG : C_SHORT; // R23 R24
  wire sym_end = (12'(tx_time + 12'h001) >= sym_len);
  wire sof_end = (12'(tx_time + 12'h001) >= C_SOF);
  wire [7:0] tx_crc_nx = crc_step(tx_crc, tx_shift[7]);
  // start on idle bus or right after a resync edge
  wire tx_start = (tx_state == TX_IDLE) && pending && (bus_idle || sync_ok); // R16 R17 R9
  wire arb_lose = (tx_state == TX_BITS) && !raw_transmit_line && rx_filt &&
    (tx_time >= C_ARB_GUARD);
  wire tx_brk = brk_hit && (tx_state != TX_IDLE); // R19

  // resync window opened by a rising edge during the separation
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_age <= 7'h00;
      sync_ok <= 1'b0;
    end
    else if (rise && rx_state == RX_IFS)
    begin
      sync_age <= 7'h00; // R15
      sync_ok <= 1'b1;
    end
    else if (sync_ok)
    begin
      sync_age <= 7'(sync_age + 7'h01);
      if (sync_age == C_SYNC_WIN)
        sync_ok <= 1'b0; // R17
    end
  end

  // symbol sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_state <= TX_IDLE;
      tx_time <= 12'h000;
      tx_shift <= 8'h00;
      tx_bits <= 3'h0;
      tx_crc <= CRC_INIT;
      tx_crc_phase <= 1'b0;
      tx_nbytes <= 4'h0;
      raw_transmit_line <= 1'b0;
    end
    else if (tx_brk || arb_lose)
    begin
      tx_state <= TX_IDLE; // R19
      raw_transmit_line <= 1'b0;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
        begin
          if (tx_start)
          begin
            tx_state <= TX_SOF;
            // aligned to the edge that opened the window
            tx_time <= sync_ok ? 12'(sync_age) : 12'h000; // R15 R16
            raw_transmit_line <= 1'b1; // R8
          end
        end
        TX_SOF:
        begin
          tx_time <= 12'(tx_time + 12'h001);
          if (sof_end)
          begin
            tx_state <= TX_BITS;
            tx_time <= 12'h000;
            tx_shift <= hold;
            tx_bits <= 3'h0;
            tx_crc <= CRC_INIT; // R8 R10
            tx_crc_phase <= 1'b0;
            tx_nbytes <= 4'h1;
            raw_transmit_line <= 1'b0;
          end
        end
        TX_BITS:
        begin
          tx_time <= 12'(tx_time + 12'h001);
          if (sym_end)
          begin
            tx_time <= 12'h000;
            raw_transmit_line <= ~raw_transmit_line;
            tx_bits <= 3'(tx_bits + 3'h1);
            tx_shift <= {tx_shift[6:0], 1'b0}; // R7
            if (!tx_crc_phase)
              tx_crc <= tx_crc_nx; // R10
            if (tx_bits == 3'h7)
            begin
              if (!tx_crc_phase && pending && tx_nbytes < MAX_DATA)
              begin
                tx_shift <= hold; // R7
                tx_nbytes <= 4'(tx_nbytes + 4'h1);
              end
              else if (!tx_crc_phase)
              begin
                tx_shift <= ~tx_crc_nx; // R10
                tx_crc_phase <= 1'b1;
              end
              else
              begin
                tx_state <= TX_IDLE;
                raw_transmit_line <= 1'b0;
              end
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // ***************************************
  // wishbone slave
  // ***************************************
  wire req = wb_req.cyc && wb_req.stb && !wb_ack_o;
  wire wr0 = req && wb_req.we && wb_req.sel[0];
  wire rd = req && !wb_req.we;
  wire wr_ctrl = wr0 && (wb_req.adr == ADR_CTRL);
  wire wr_stat = wr0 && (wb_req.adr == ADR_STAT);
  wire wr_data = wr0 && (wb_req.adr == ADR_DATA);
  wire rd_data = rd && (wb_req.adr == ADR_DATA);
  // byte leaves the holding register as the sequencer takes it
  wire take = (tx_state == TX_SOF && sof_end) || (tx_state == TX_BITS && sym_end &&
    tx_bits == 3'h7 && !tx_crc_phase && pending && tx_nbytes < MAX_DATA);
  wire [31:0] stat_word = {23'h0, rx_filt, pending, (tx_state != TX_IDLE), flags};
  wire [31:0] rd_word = (wb_req.adr == ADR_CTRL) ? {31'h0, fourx} :
    (wb_req.adr == ADR_STAT) ? stat_word :
    (wb_req.adr == ADR_DATA) ? {24'h0, rx_data} : 32'h0;
  status_t set_s;
  status_t clr_s;
  assign set_s = '{tx_err: tx_brk, arb_lost: arb_lose, // R19
    invalid: rx_brk || rx_bad_bit || sof_bad, // R20
    crc_err: eod_ev && (rx_crc != CRC_GOOD), // R11
    eof: eof_ev, rx_full: rx_bit_ev && rx_bits == 3'h7}; // R13
  assign clr_s = wr_stat ? status_t'(wb_req.dat[5:0]) : '0;

  // bus answer one clock after the request
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? rd_word : 32'h0;
    end
  end

  // control, holding register and sticky flags; a set beats a clear, except for fourx where the break clear wins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fourx <= CTRL_RESET;
      hold <= 8'h00;
      pending <= 1'b0;
      flags <= '0;
    end
    else
    begin
      // hardware clear wins over a software write in the same cycle
      if (rx_brk)
        fourx <= 1'b0; // R21
      else if (wr_ctrl)
        fourx <= wb_req.dat[0];
      if (wr_data)
      begin
        hold <= wb_req.dat[7:0];
        pending <= 1'b1;
      end
      else if (take)
        pending <= 1'b0;
      flags <= (flags & ~(clr_s | status_t'({5'h0, rd_data}))) | set_s; // R11 R13
    end
  end

  // ***************************************
  // assertions
  // ***************************************
  logic [5:0] raw_run; // clocks the raw line has held its level
  logic raw_last;
  logic [11:0] act_cnt; // clocks the transmit line has been active
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      raw_run <= 6'h00;
      raw_last <= 1'b0;
      act_cnt <= 12'h000;
    end
    else
    begin
      raw_last <= raw_receive_line;
      raw_run <= (raw_receive_line != raw_last) ? 6'h00 :
        (raw_run == 6'h3f) ? raw_run : 6'(raw_run + 6'h01);
      act_cnt <= raw_transmit_line ? 12'(act_cnt + 12'h001) : 12'h000;
    end
  end

  property p_rise_at_top;
    @(posedge clk) disable iff (rst) $rose(rx_filt) |-> filt_cnt == FILT_MAX;
  endproperty
  a_rise_at_top: assert property (p_rise_at_top) else $error("filter rose early"); // R3
  property p_fall_at_bottom;
    @(posedge clk) disable iff (rst) $fell(rx_filt) |-> filt_cnt == FILT_MIN;
  endproperty
  a_fall_at_bottom: assert property (p_fall_at_bottom) else $error("filter fell early"); // R4
  property p_hold_between;
    @(posedge clk) disable iff (rst)
      (filt_cnt != FILT_MAX && filt_cnt != FILT_MIN) |-> $stable(rx_filt);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("filter moved mid-range"); // R5
  property p_count_step;
    @(posedge clk) disable iff (rst)
      sample && filt_cnt != FILT_MAX |=> filt_cnt == 4'($past(filt_cnt) + 4'h1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step up"); // R2
  property p_clean_delay;
    @(posedge clk) disable iff (rst) raw_run == 6'h0f |-> rx_filt == raw_receive_line;
  endproperty
  a_clean_delay: assert property (p_clean_delay) else $error("filter slower than 16"); // R6
  property p_no_break_tx;
    @(posedge clk) disable iff (rst) act_cnt <= C_SOF;
  endproperty
  a_no_break_tx: assert property (p_no_break_tx) else $error("transmit active too long"); // R19
  property p_sof_active;
    @(posedge clk) disable iff (rst) tx_state == TX_SOF |-> raw_transmit_line;
  endproperty
  a_sof_active: assert property (p_sof_active) else $error("sof not active"); // R8
  property p_crc_flag;
    @(posedge clk) disable iff (rst) eod_ev && rx_crc != CRC_GOOD |=> flags.crc_err;
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc error not flagged"); // R11
  property p_brk_fourx;
    @(posedge clk) disable iff (rst) rx_brk |=> !fourx && flags.invalid;
  endproperty
  a_brk_fourx: assert property (p_brk_fourx) else $error("break not handled"); // R20 R21
  property p_eof_flag;
    @(posedge clk) disable iff (rst) eof_ev |=> flags.eof && rx_state == RX_IFS;
  endproperty
  a_eof_flag: assert property (p_eof_flag) else $error("eof not flagged"); // R13
  c_tx_start: cover property (@(posedge clk) disable iff (rst) tx_start);
  c_resync: cover property (@(posedge clk) disable iff (rst) tx_start && sync_ok);
  c_eof: cover property (@(posedge clk) disable iff (rst) eof_ev);
  c_break: cover property (@(posedge clk) disable iff (rst) rx_brk);
endmodule

// ==== design/vpw_mux_pkg.sv ====
// constants, types and carriers for the vpw bus mux interface
// assumes a single 10 MHz clock that also serves as the mux clock
package vpw_mux_pkg;
  // ***************************************
  // timing
  // ***************************************
  localparam int CLK_PERIOD_NS = 100; // mux_clock_period
  localparam int T_SHORT_US = 64; // short bit
  localparam int T_LONG_US = 128; // long bit
  localparam int T_SOF_US = 200; // start of frame
  localparam int T_EOD_US = 200; // end of data
  localparam int T_BREAK_US = 240; // break threshold
  localparam int T_EOF_US = 280; // end of frame
  localparam int T_IFS_US = 20; // inter-frame separation
  localparam int T_MIN_US = 34; // shortest accepted pulse
  localparam int T_SPLIT_US = 96; // short/long boundary
  localparam int T_LMAX_US = 164; // long/sof boundary
  localparam logic [11:0] C_SHORT = 12'((T_SHORT_US * 1000) / CLK_PERIOD_NS);
  localparam logic [11:0] C_LONG = 12'((T_LONG_US * 1000) / CLK_PERIOD_NS);
  localparam logic [11:0] C_SOF = 12'((T_SOF_US * 1000) / CLK_PERIOD_NS);
  localparam logic [11:0] C_EOD = 12'((T_EOD_US * 1000) / CLK_PERIOD_NS);
  localparam logic [11:0] C_BREAK = 12'((T_BREAK_US * 1000) / CLK_PERIOD_NS);
  localparam logic [11:0] C_EOF = 12'((T_EOF_US * 1000) / CLK_PERIOD_NS);
  localparam logic [11:0] C_IDLE = 12'(((T_EOF_US + T_IFS_US) * 1000) / CLK_PERIOD_NS);
  localparam logic [11:0] C_MIN = 12'((T_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] C_SPLIT = 12'((T_SPLIT_US * 1000) / CLK_PERIOD_NS);
  localparam logic [11:0] C_LMAX = 12'((T_LMAX_US * 1000) / CLK_PERIOD_NS);
  localparam logic [6:0] C_SYNC_WIN = 7'h68; // 104 mux clocks
  localparam logic [11:0] C_ARB_GUARD = 12'h020; // covers filter delay
  localparam logic [11:0] C_TIME_SAT = 12'hff0;
  // ***************************************
  // filter, crc, frame
  // ***************************************
  localparam logic [3:0] FILT_MAX = 4'hf;
  localparam logic [3:0] FILT_MIN = 4'h0;
  localparam logic [7:0] CRC_POLY = 8'h1d;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [7:0] CRC_GOOD = 8'hc4;
  localparam logic [3:0] MAX_DATA = 4'hb; // plus crc makes 12
  // ***************************************
  // registers
  // ***************************************
  localparam logic [3:0] ADR_CTRL = 4'h0; // link_control_two
  localparam logic [3:0] ADR_STAT = 4'h4; // state_vector_register
  localparam logic [3:0] ADR_DATA = 4'h8; // link_data_register
  localparam logic CTRL_RESET = 1'b0;
  typedef struct packed {
    logic tx_err;
    logic arb_lost;
    logic invalid;
    logic crc_err;
    logic eof;
    logic rx_full;
  } status_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef enum logic [2:0] {RX_IDLE, RX_SOF, RX_DATA, RX_EOD, RX_IFS} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_SOF, TX_BITS} tx_state_t;
endpackage

// ==== verification/tb_top.sv ====
// self-checking bench: wishbone register traffic plus a bus partner node
// assumes the design package and the partner model are compiled first
`timescale 1ns/1ps
module tb_top;
  import vpw_mux_pkg::*;
  logic clk, rst, wb_ack_o, raw_receive_line, raw_transmit_line;
  wb_req_t wb_req;
  logic [31:0] wb_dat_o, rd;
  logic [7:0] b;
  int n_errors = 0;
  int n_tests = 0;
  int seed = 32'h6a45;
  vpw_bus_mux_interface i_dut (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .raw_receive_line(raw_receive_line),
    .raw_transmit_line(raw_transmit_line));
  vpw_bus_model i_bus (.clk(clk), .rst(rst), .tx_line(raw_transmit_line),
    .rx_line(raw_receive_line));
  // ***************************
  // helpers
  // ***************************
  // expected crc: msb first, preset ones, inverted
  function automatic logic [7:0] crc8(input logic [7:0] d);
    logic [7:0] r;
    r = CRC_INIT;
    for (int i = 7; i >= 0; i--)
      r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return ~r;
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    int t;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (wb_ack_o !== 1'b1 && t < 50);
    rd = wb_dat_o;
    wb_req <= '0;
    if (t >= 50)
      chk("wb ack", 32'h1, 32'h0);
  endtask
  // raw level for n clocks, status read d clocks in
  task automatic pulse(input logic lvl, input int n, input int d, input logic exp);
    fork
      i_bus.hold(lvl, n);
      begin
        repeat (d) @(posedge clk);
        wb(1'b0, ADR_STAT, 32'h0);
      end
    join
    chk("filtered line", exp, rd[8]);
  endtask
  // poll until the transmitter is neither busy nor holding a byte
  task automatic wait_quiet();
    int t;
    t = 0;
    do
    begin
      repeat (100) @(posedge clk);
      wb(1'b0, ADR_STAT, 32'h0);
      t++;
    end
    while (rd[7:6] !== 2'b00 && t < 600);
    chk("tx done", 32'h0, rd[7:6]);
  endtask
  // partner frame, then a partner sof inside the separation and a late or early write
  task automatic ifs_case(input int dly, input logic exp);
    logic [7:0] d;
    d = 8'($random(seed));
    wb(1'b1, ADR_STAT, 32'h3f);
    i_bus.send_frame(8'h55, crc8(8'h55), 2880);
    wb(1'b0, ADR_STAT, 32'h0);
    chk("rx eof crc", 32'h1, rd[2:1]);
    fork
      i_bus.hold(1'b1, 2000);
      begin
        repeat (dly) @(posedge clk);
        wb(1'b1, ADR_DATA, {24'h0, d});
        repeat (30) @(posedge clk);
        chk("joined sof", exp, raw_transmit_line);
      end
    join
    i_bus.hold(1'b0, 10);
    wait_quiet();
    chk("tx byte", d, i_bus.got[0]);
    chk("tx crc", crc8(d), i_bus.got[1]);
    chk("tx bytes", 32'h2, i_bus.n_got);
    if (!exp)
      chk("sof length", 32'd2000, i_bus.sof_len);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ***************************
  // clock, watchdog, sequence
  // ***************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (130000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial
  begin
    rst = 1'b1;
    wb_req = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // every place reads zero after reset, the unmapped one too
    for (int a = 0; a < 16; a += 4)
    begin
      wb(1'b0, 4'(a), 32'h0);
      chk("reset read", 32'h0, rd);
    end
    pulse(1'b1, 14, 10, 1'b0);
    pulse(1'b0, 40, 20, 1'b0);
    pulse(1'b1, 60, 25, 1'b1);
    pulse(1'b0, 14, 10, 1'b1);
    pulse(1'b0, 40, 25, 1'b0);
    // break inside a frame in four-times mode; the filter pulses left flags behind
    wb(1'b1, ADR_STAT, 32'h3f);
    wb(1'b1, ADR_CTRL, 32'h1);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("fourx set", 32'h1, rd[0]);
    i_bus.hold(1'b1, 2000);
    i_bus.hold(1'b0, 640);
    i_bus.hold(1'b1, 2600);
    i_bus.hold(1'b0, 400);
    wb(1'b0, ADR_STAT, 32'h0);
    chk("break invalid", 32'h2, {rd[3], rd[0]});
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("fourx cleared", 32'h0, rd[0]);
    // frame with a corrupted crc byte
    wb(1'b1, ADR_STAT, 32'h3f);
    b = 8'($random(seed));
    i_bus.send_frame(b, ~crc8(b), 2300);
    wb(1'b0, ADR_STAT, 32'h0);
    chk("eod no flag", 32'h0, rd[1]);
    i_bus.hold(1'b0, 800);
    wb(1'b0, ADR_STAT, 32'h0);
    chk("crc error eof", 32'h3, rd[2:1]);
    ifs_case(40, 1'b1);
    // let the own frame pass its end of data before the partner speaks again
    repeat (2400) @(posedge clk);
    ifs_case(200, 1'b0);
    chk("no break sent", 32'h1, i_bus.max_act < 2400);
    give_verdict();
  end
endmodule

// ==== verification/vpw_bus_model.sv ====
// far-side bus node: drives its own symbols, decodes the frames the dut sends
// assumes an active-high dominant bus that rests passive (low) when released
`timescale 1ns/1ps
module vpw_bus_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_line,
  output logic rx_line
);
  import vpw_mux_pkg::*;
  logic drv = 1'b0; // own drive, high means active
  logic act = 1'b0; // level of the next own bit
  logic last; // dut level seen at the last edge
  logic in_frame; // decoder between sof and eod
  logic [7:0] acc; // bit collector
  logic [7:0] got [0:15]; // decoded dut bytes
  int run, nb, n_got, sof_len, max_act;
  // wired or: an active node dominates, an unknown dut pin counts as passive
  assign rx_line = drv | (tx_line === 1'b1);
  // ***************************
  // own symbols
  // ***************************
  task automatic hold(input logic lvl, input int n);
    drv <= lvl;
    repeat (n) @(posedge clk);
  endtask
  // bits alternate level, the first one after sof is passive
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      hold(act, (act ^ b[i]) ? 1280 : 640);
      act = ~act;
    end
  endtask
  task automatic send_frame(input logic [7:0] b0, input logic [7:0] b1, input int gap);
    hold(1'b1, 2000);
    act = 1'b0;
    send_byte(b0);
    send_byte(b1);
    hold(1'b0, gap);
  endtask
  // ***************************
  // decoder of dut runs
  // ***************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      last <= 1'b0;
      run <= 1;
      in_frame <= 1'b0;
      max_act <= 0;
    end
    else if (tx_line == last)
    begin
      // same level: lengthen the run, close the frame on a long passive
      run <= run + 1;
      if (last && run > max_act)
        max_act <= run;
      if (!last && run > 1800)
        in_frame <= 1'b0;
    end
    else
    begin
      // an edge ends a run: long active opens a frame, else a bit
      run <= 1;
      last <= tx_line;
      if (last && run >= 1800)
      begin
        sof_len <= run;
        in_frame <= 1'b1;
        nb <= 0;
        n_got <= 0;
      end
      else if (in_frame)
      begin
        acc <= {acc[6:0], last ^ (run >= 960)};
        nb <= nb + 1;
        if (nb % 8 == 7)
          got[n_got[3:0]] <= {acc[6:0], last ^ (run >= 960)};
        if (nb % 8 == 7)
          n_got <= n_got + 1;
      end
    end
  end
endmodule
